/* File: logic/pmds_direction_store.sv */
// Operation
// - 2048 mailbox registers, numbered 1..2048, read and written from all five ports.
// - Rack scan reaches only mailbox 1..2048; other locals only via message ports.
// - Configuration is changed only by read/write messages addressed to the module.
// - Serve locally if route empty, ends entry drop, null drop 204, or unknown.
// - Controller register number equals rack start address plus mailbox number.
// - After reset every mailbox is a controller output, status reads A000.
// - External write switches the written mailbox status from A000 to E000.
// - Input direction stays until module reset or power cycle.
// - Input mailboxes: controller may read only; external parties read and write.
// - Output mailboxes accept controller writes; external parties read that value.
// - Writes from data ports 1..4, network port, auto-transfer are external.
// - Mailboxes outside the rack window remain usable by external parties.
`include "pmds_defines.svh"

module pmds_direction_store
    import pmds_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic ext_valid_in,
    input wire pmds_ext_req_t ext_req_in,
    output logic ext_ack_out,
    output logic ext_fwd_out,
    output pmds_rsp_t ext_rsp_out,
    input wire logic rack_valid_in,
    input wire logic rack_we_in,
    input wire logic [15:0] rack_plc_reg_in,
    input wire logic [`PMDS_DATA_W-1:0] rack_wdata_in,
    output logic rack_ack_out,
    output logic rack_refused_out,
    output logic rack_input_out,
    output logic [`PMDS_DATA_W-1:0] rack_rdata_out
);

    // Mailbox number range check, shared by both requesters
    function automatic logic is_mailbox(input logic [15:0] regno);
        is_mailbox = (regno >= `PMDS_MBX_FIRST) && (regno <= `PMDS_MBX_LAST);
    endfunction : is_mailbox

    function automatic logic [`PMDS_IDX_W-1:0] to_index(input logic [15:0] regno);
        logic [15:0] zero_based;
        zero_based = regno - `PMDS_MBX_FIRST;
        to_index = zero_based[`PMDS_IDX_W-1:0];
    endfunction : to_index

    logic [15:0] rack_start_r;
    logic [`PMDS_DROP_W-1:0] drop_r [0:`PMDS_PORTS-1];
    logic [`PMDS_MBX_COUNT-1:0] dir_in_r;

    // Stage one bookkeeping
    logic s1_valid_r;
    logic s1_ext_r;
    logic s1_fwd_r;
    logic s1_err_r;
    logic s1_cfg_r;
    logic s1_input_r;
    logic s1_refused_r;
    logic [`PMDS_DATA_W-1:0] s1_cfg_data_r;

    logic [`PMDS_DATA_W-1:0] ram_rdata;
    logic ram_en;
    logic ram_we;
    logic [`PMDS_IDX_W-1:0] ram_addr;
    logic [`PMDS_DATA_W-1:0] ram_wdata;

    logic [`PMDS_DROP_W-1:0] entry_drop;
    logic drop_known;
    logic ext_local;
    logic ext_mbx;
    logic [`PMDS_IDX_W-1:0] ext_idx;
    logic ext_cfg_hit;
    logic [`PMDS_DATA_W-1:0] ext_cfg_data;
    logic rack_take;
    logic [15:0] rack_rel;
    logic rack_mbx;
    logic [`PMDS_IDX_W-1:0] rack_idx;
    logic rack_blocked;

    // Drop of the port the message entered by; auto-transfer has none
    always_comb begin
        entry_drop = `PMDS_NULL_DROP;
        drop_known = 1'b0;
        for (int p = 0; p < `PMDS_PORTS; p++) begin
            if (ext_req_in.src == pmds_src_t'(p)) begin
                entry_drop = drop_r[p];
            end
            if (ext_req_in.last_drop == drop_r[p]) begin
                drop_known = 1'b1;
            end
        end
    end

    // Local-service decision from the route
    assign ext_local = (ext_req_in.route_len == '0) ||
                       (ext_req_in.last_drop == entry_drop) ||
                       (ext_req_in.last_drop == `PMDS_NULL_DROP) ||
                       !drop_known;
    assign ext_mbx = is_mailbox(ext_req_in.regno);
    assign ext_idx = to_index(ext_req_in.regno);

    // Configuration register decode
    always_comb begin
        ext_cfg_hit = 1'b0;
        ext_cfg_data = '0;
        if (ext_req_in.regno == `PMDS_REG_RACK_START) begin
            ext_cfg_hit = 1'b1;
            ext_cfg_data = rack_start_r;
        end
        for (int p = 0; p < `PMDS_PORTS; p++) begin
            if (ext_req_in.regno == `PMDS_REG_DROP_BASE + 16'(p)) begin
                ext_cfg_hit = 1'b1;
                ext_cfg_data = {8'h00, drop_r[p]};
            end
        end
    end

    // Rack window: controller register minus start gives mailbox number
    assign rack_rel = rack_plc_reg_in - rack_start_r;
    assign rack_mbx = is_mailbox(rack_rel);
    assign rack_idx = to_index(rack_rel);
    assign rack_take = rack_valid_in && !ext_valid_in;
    assign rack_blocked = rack_we_in && dir_in_r[rack_idx];

    // Message side has priority over the scan, scan simply waits
    always_comb begin
        ram_en = 1'b0;
        ram_we = 1'b0;
        ram_addr = rack_idx;
        ram_wdata = rack_wdata_in;
        if (ext_valid_in) begin
            ram_en = ext_local && ext_mbx;
            ram_we = ext_req_in.we;
            ram_addr = ext_idx;
            ram_wdata = ext_req_in.wdata;
        end else if (rack_take && rack_mbx) begin
            ram_en = 1'b1;
            ram_we = rack_we_in && !rack_blocked;
        end
    end

    pmds_store_ram u_ram (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .en_in(ram_en),
        .we_in(ram_we),
        .addr_in(ram_addr),
        .wdata_in(ram_wdata),
        .rdata_out(ram_rdata)
    );

    // Direction flags; only reset returns a mailbox to output
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dir_in_r <= '0;
        end else if (ext_valid_in && ext_local && ext_mbx && ext_req_in.we) begin
            dir_in_r[ext_idx] <= 1'b1;
        end
    end

    // Configuration written only by local messages
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rack_start_r <= `PMDS_RACK_START_RST;
        end else if (ext_valid_in && ext_local && ext_req_in.we &&
                     ext_req_in.regno == `PMDS_REG_RACK_START) begin
            rack_start_r <= ext_req_in.wdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PMDS_PORTS; g++) begin : g_drop
            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    drop_r[g] <= `PMDS_DROP_RST;
                end else if (ext_valid_in && ext_local && ext_req_in.we &&
                             ext_req_in.regno == `PMDS_REG_DROP_BASE + 16'(g)) begin
                    drop_r[g] <= ext_req_in.wdata[`PMDS_DROP_W-1:0];
                end
            end
        end
    endgenerate

    // Stage one: remember what the memory cycle was for
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_valid_r <= 1'b0;
            s1_ext_r <= 1'b0;
            s1_fwd_r <= 1'b0;
            s1_err_r <= 1'b0;
            s1_cfg_r <= 1'b0;
            s1_input_r <= 1'b0;
            s1_refused_r <= 1'b0;
            s1_cfg_data_r <= '0;
        end else begin
            s1_valid_r <= ext_valid_in || rack_take;
            s1_ext_r <= ext_valid_in;
            s1_fwd_r <= ext_valid_in && !ext_local;
            s1_cfg_r <= ext_cfg_hit;
            s1_cfg_data_r <= ext_cfg_data;
            if (ext_valid_in) begin
                s1_err_r <= !ext_mbx && !ext_cfg_hit;
                // A write leaves the mailbox an input even if it was not before
                s1_input_r <= dir_in_r[ext_idx] || ext_req_in.we;
                s1_refused_r <= 1'b0;
            end else begin
                s1_err_r <= 1'b0;
                s1_input_r <= dir_in_r[rack_idx];
                s1_refused_r <= !rack_mbx || rack_blocked;
            end
        end
    end

    // Stage two: registered answers, one-cycle pulses
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_ack_out <= 1'b0;
            ext_fwd_out <= 1'b0;
            ext_rsp_out <= '0;
            rack_ack_out <= 1'b0;
            rack_refused_out <= 1'b0;
            rack_input_out <= 1'b0;
            rack_rdata_out <= '0;
        end else begin
            ext_ack_out <= s1_valid_r && s1_ext_r && !s1_fwd_r;
            ext_fwd_out <= s1_valid_r && s1_fwd_r;
            rack_ack_out <= s1_valid_r && !s1_ext_r;
            rack_refused_out <= s1_valid_r && !s1_ext_r && s1_refused_r;
            if (s1_valid_r && s1_ext_r) begin
                ext_rsp_out.err <= s1_err_r;
                ext_rsp_out.rdata <= s1_cfg_r ? s1_cfg_data_r : (s1_err_r ? '0 : ram_rdata);
                ext_rsp_out.status <= s1_input_r ? `PMDS_STAT_INPUT : `PMDS_STAT_OUTPUT;
            end
            if (s1_valid_r && !s1_ext_r) begin
                rack_input_out <= s1_input_r;
                rack_rdata_out <= s1_refused_r ? '0 : ram_rdata;
            end
        end
    end

endmodule : pmds_direction_store

/* File: pkg/pmds_defines.svh */
`ifndef PMDS_DEFINES_SVH
`define PMDS_DEFINES_SVH

// Mailbox geometry
`define PMDS_MBX_COUNT 2048
`define PMDS_IDX_W 11
`define PMDS_DATA_W 16
`define PMDS_MBX_FIRST 16'h0001
`define PMDS_MBX_LAST 16'h0800

// Direction status words
`define PMDS_STAT_OUTPUT 16'hA000
`define PMDS_STAT_INPUT 16'hE000

// Routing
`define PMDS_PORTS 5
`define PMDS_NULL_DROP 8'hCC
`define PMDS_DROP_W 8
`define PMDS_ROUTE_LEN_W 4

// Local configuration registers, reached only by messages
`define PMDS_REG_RACK_START 16'h1F41
`define PMDS_REG_DROP_BASE 16'h1F42
`define PMDS_RACK_START_RST 16'h0000
`define PMDS_DROP_RST 8'h00

`endif

/* File: pkg/pmds_pkg.sv */
`include "pmds_defines.svh"

package pmds_pkg;

    // Origin of an external message
    typedef enum logic [2:0] {
        PMDS_SRC_PORT1,
        PMDS_SRC_PORT2,
        PMDS_SRC_PORT3,
        PMDS_SRC_PORT4,
        PMDS_SRC_NET,
        PMDS_SRC_AUTO
    } pmds_src_t;

    // One read or write request message from a port
    typedef struct packed {
        pmds_src_t src;
        logic we;
        logic [15:0] regno;
        logic [`PMDS_DATA_W-1:0] wdata;
        logic [`PMDS_ROUTE_LEN_W-1:0] route_len;
        logic [`PMDS_DROP_W-1:0] last_drop;
    } pmds_ext_req_t;

    // Answer to a local message
    typedef struct packed {
        logic [`PMDS_DATA_W-1:0] rdata;
        logic [`PMDS_DATA_W-1:0] status;
        logic err;
    } pmds_rsp_t;

endpackage : pmds_pkg

/* File: logic/pmds_store_ram.sv */
`include "pmds_defines.svh"

// Single-port mailbox storage, read data registered
module pmds_store_ram (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic en_in,
    input wire logic we_in,
    input wire logic [`PMDS_IDX_W-1:0] addr_in,
    input wire logic [`PMDS_DATA_W-1:0] wdata_in,
    output logic [`PMDS_DATA_W-1:0] rdata_out
);

    logic [`PMDS_DATA_W-1:0] mem_r [0:`PMDS_MBX_COUNT-1];

    // Array left unreset so it maps to block memory
    always_ff @(posedge mclk_in) begin
        if (en_in && we_in) begin
            mem_r[addr_in] <= wdata_in;
        end
    end

    // Write-first read port
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= '0;
        end else if (en_in) begin
            rdata_out <= we_in ? wdata_in : mem_r[addr_in];
        end
    end

endmodule : pmds_store_ram

/* File: testbench/pmds_chk.sv */
module pmds_chk
    import pmds_pkg::*;
(
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic ext_valid_in,
    input wire pmds_ext_req_t ext_req_in,
    input wire logic ext_ack_out,
    input wire logic ext_fwd_out,
    input wire pmds_rsp_t ext_rsp_out,
    input wire logic rack_valid_in,
    input wire logic rack_we_in,
    input wire logic rack_ack_out,
    input wire logic rack_refused_out,
    input wire logic rack_input_out,
    input wire logic [15:0] rack_rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Local mailbox write; empty route keeps it local
    wire logic mbx_w = ext_valid_in && ext_req_in.we && ext_req_in.route_len == 4'h0 &&
        ext_req_in.regno >= 16'h0001 && ext_req_in.regno <= 16'h0800;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    property p_one; ext_valid_in |-> ##2 (ext_ack_out ^ ext_fwd_out); endproperty
    a_one: assert property (p_one) else $error("no single answer");
    property p_empty; ext_valid_in && ext_req_in.route_len == 4'h0 |-> ##2 ext_ack_out; endproperty
    a_empty: assert property (p_empty) else $error("empty route not local");
    property p_null; ext_valid_in && ext_req_in.last_drop == 8'hCC |-> ##2 ext_ack_out; endproperty
    a_null: assert property (p_null) else $error("null drop not local");
    property p_flip; mbx_w |-> ##2 ext_rsp_out.status == 16'hE000 && !ext_rsp_out.err; endproperty
    a_flip: assert property (p_flip) else $error("write did not flip");
    property p_echo; mbx_w |-> ##2 ext_rsp_out.rdata == $past(ext_req_in.wdata, 2); endproperty
    a_echo: assert property (p_echo) else $error("write echo wrong");
    property p_rlat; rack_valid_in && !ext_valid_in |-> ##2 rack_ack_out; endproperty
    a_rlat: assert property (p_rlat) else $error("scan unanswered");
    property p_ro; rack_ack_out && rack_input_out && $past(rack_we_in, 2) |-> rack_refused_out; endproperty
    a_ro: assert property (p_ro) else $error("input overwritten");
    property p_zero; rack_ack_out && rack_refused_out |-> rack_rdata_out == 16'h0000; endproperty
    a_zero: assert property (p_zero) else $error("refused data shown");
    c_fwd: cover property (ext_fwd_out);
    c_ref: cover property (rack_ack_out && rack_refused_out);
    c_in: cover property (rack_ack_out && rack_input_out);
endmodule : pmds_chk

bind pmds_direction_store pmds_chk u_pmds_chk (.mclk_in, .arst_n_in, .ext_valid_in, .ext_req_in,
    .ext_ack_out, .ext_fwd_out, .ext_rsp_out, .rack_valid_in, .rack_we_in, .rack_ack_out,
    .rack_refused_out, .rack_input_out, .rack_rdata_out);

/* File: testbench/pmds_plc_model.sv */
module pmds_plc_model (
    input wire logic mclk_in,
    input wire logic rack_ack_out,
    input wire logic rack_refused_out,
    input wire logic rack_input_out,
    input wire logic [15:0] rack_rdata_out,
    output logic rack_valid_in = 1'b0,
    output logic rack_we_in = 1'b0,
    output logic [15:0] rack_plc_reg_in = 16'h0000,
    output logic [15:0] rack_wdata_in = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] got_d;
    logic got_i, got_r;
    // Held until ack is sampled; extra takes drain before return
    task automatic xfer(input logic we, input logic [15:0] r, input logic [15:0] w);
        int n;
        n = 0;
        {rack_we_in, rack_plc_reg_in, rack_wdata_in, rack_valid_in} = {we, r, w, 1'b1};
        do begin
            @(posedge mclk_in);
            n++;
        end while (!rack_ack_out && n < 8);
        // No ack within the limit leaves unknowns, which fail every compare
        {got_d, got_i, got_r} = rack_ack_out ? {rack_rdata_out, rack_input_out, rack_refused_out} : 'x;
        #1 rack_valid_in = 1'b0;
        {rack_plc_reg_in, rack_wdata_in} = {~r, ~w}; // Released lines lose old value
        repeat (4) @(posedge mclk_in);
        #1;
    endtask : xfer
endmodule : pmds_plc_model

/* File: testbench/tb.sv */
module tb;
    import pmds_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] START = 16'h0004;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic ext_valid_in = 1'b0;
    pmds_ext_req_t ext_req_in = '0;
    logic ext_ack_out, ext_fwd_out, rack_valid_in, rack_we_in, rack_ack_out, rack_refused_out, rack_input_out;
    logic [15:0] rack_plc_reg_in, rack_wdata_in, rack_rdata_out, d, k;
    pmds_rsp_t ext_rsp_out;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [3:0] rl [5] = '{4'h2, 4'h2, 4'h1, 4'h3, 4'h0};
    logic [7:0] ld [5] = '{8'h10, 8'h10, 8'hCC, 8'h77, 8'h10};
    logic [15:0] fw [5] = '{16'h0, 16'h1, 16'h0, 16'h0, 16'h0};

    pmds_direction_store u_pmds_direction_store (.mclk_in, .arst_n_in, .ext_valid_in, .ext_req_in,
        .ext_ack_out, .ext_fwd_out, .ext_rsp_out, .rack_valid_in, .rack_we_in, .rack_plc_reg_in,
        .rack_wdata_in, .rack_ack_out, .rack_refused_out, .rack_input_out, .rack_rdata_out);
    pmds_plc_model u_pmds_plc_model (.mclk_in, .rack_ack_out, .rack_refused_out, .rack_input_out,
        .rack_rdata_out, .rack_valid_in, .rack_we_in, .rack_plc_reg_in, .rack_wdata_in);

    // 50 MHz clock
    always #10 mclk_in = ~mclk_in;
    // Hang guard, far above the expected run length
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    function automatic logic [15:0] stat(input logic inp);
        return inp ? 16'hE000 : 16'hA000;
    endfunction : stat

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk

    // One message; the pulse answer stands just after the first edge past the take
    task automatic ext(input pmds_src_t s, input logic we, input logic [15:0] r, input logic [15:0] w,
        input logic [3:0] l, input logic [7:0] dr);
        ext_req_in = '{s, we, r, w, l, dr};
        ext_valid_in = 1'b1;
        @(posedge mclk_in);
        #1 ext_valid_in = 1'b0;
        ext_req_in.wdata = ~w;
        @(posedge mclk_in);
        #1;
    endtask : ext

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        void'($urandom(87158));
        repeat (3) @(posedge mclk_in);
        #1 arst_n_in = 1'b1;
        ext(PMDS_SRC_NET, 1'b1, 16'h1F41, START, 4'h0, 8'h00);
        chk(16'(ext_ack_out), 16'h1, "cfg");
        ext(PMDS_SRC_NET, 1'b1, 16'h1F42, 16'h0010, 4'h0, 8'h00);
        ext(PMDS_SRC_PORT3, 1'b0, 16'h1F42, 16'h0, 4'h0, 8'h00);
        chk(ext_rsp_out.rdata, 16'h0010, "cfg rd");
        for (int i = 0; i < 4; i++) begin
            k = (i == 0) ? 16'h0001 : (i == 3) ? 16'h0800 : 16'($urandom_range(255, 2));
            d = 16'($urandom);
            u_pmds_plc_model.xfer(1'b0, START + k, 16'h0);
            chk(16'(u_pmds_plc_model.got_i), 16'h0, "dir");
            u_pmds_plc_model.xfer(1'b1, START + k, d);
            chk(16'(u_pmds_plc_model.got_r), 16'h0, "out wr");
            ext(pmds_src_t'(i), 1'b0, k, 16'h0, 4'h0, 8'h00);
            chk(ext_rsp_out.rdata, d, "ext rd");
            chk(ext_rsp_out.status, stat(1'b0), "stat");
        end
        $display("test output done");
        for (int i = 0; i < 6; i++) begin
            // Input mailboxes kept in one contiguous block
            k = 16'h0100 + 16'(i);
            d = 16'($urandom);
            ext(pmds_src_t'(i), 1'b1, k, d, 4'h0, 8'h00);
            chk(ext_rsp_out.status, stat(1'b1), "flip");
            u_pmds_plc_model.xfer(1'b1, START + k, ~d);
            chk(16'(u_pmds_plc_model.got_r), 16'h1, "ro");
            u_pmds_plc_model.xfer(1'b0, START + k, 16'h0);
            chk(u_pmds_plc_model.got_d, d, "in rd");
        end
        $display("test input done");
        for (int i = 0; i < 5; i++) begin
            ext(i == 0 ? PMDS_SRC_PORT1 : PMDS_SRC_PORT2, 1'b1, 16'h0200, 16'h5A5A, rl[i], ld[i]);
            chk(16'(ext_fwd_out), fw[i], "route");
        end
        u_pmds_plc_model.xfer(1'b0, START + 16'h0200, 16'h0);
        chk(16'(u_pmds_plc_model.got_i), 16'h1, "route dir");
        $display("test route done");
        ext(PMDS_SRC_PORT4, 1'b0, 16'h0801, 16'h0, 4'h0, 8'h00);
        chk(16'(ext_rsp_out.err), 16'h1, "err");
        u_pmds_plc_model.xfer(1'b0, START, 16'h0);
        chk(16'(u_pmds_plc_model.got_r), 16'h1, "win lo");
        u_pmds_plc_model.xfer(1'b0, START + 16'h0801, 16'h0);
        chk(16'(u_pmds_plc_model.got_r), 16'h1, "win hi");
        $display("test window done");
        arst_n_in = 1'b0;
        repeat (3) @(posedge mclk_in);
        #1 arst_n_in = 1'b1;
        u_pmds_plc_model.xfer(1'b0, 16'h0100, 16'h0);
        chk(16'(u_pmds_plc_model.got_i), 16'h0, "reset dir");
        $display("test reset done");
        tally_and_finish();
    end
endmodule : tb
